// ===== src/ssrf_defs.vh
// constants for the supervisor special register file
// assumes a 32-bit core reaching the registers over apb
`ifndef SSRF_DEFS_VH
`define SSRF_DEFS_VH

// register indices (byte address = index * 4)
`define SSRF_IDX_MSR      7'h00
`define SSRF_IDX_VER      7'h01
`define SSRF_IDX_SDR      7'h02
`define SSRF_IDX_DAR      7'h03
`define SSRF_IDX_STORAGE_FAULT_CAUSE_REG    7'h04
`define SSRF_IDX_SAVE_RESTORE_FIRST     7'h05
`define SSRF_IDX_SAVE_RESTORE_SECOND     7'h06
`define SSRF_IDX_FPEC     7'h07
`define SSRF_IDX_TBL      7'h08
`define SSRF_IDX_TBU      7'h09
`define SSRF_IDX_DEC      7'h0a
`define SSRF_IDX_EAR      7'h0b
`define SSRF_IDX_DATA_BREAKPOINT_REG     7'h0c
`define SSRF_IDX_PIR      7'h0d
`define SSRF_IDX_STAT     7'h0e
`define SSRF_IDX_DIV      7'h0f
`define SSRF_IDX_SPRG     7'h10
`define SSRF_IDX_BAT      7'h20
`define SSRF_IDX_SEG      7'h30

// machine state bit positions (bit 0 is lsb, numbering lsb-first)
`define SSRF_MSR_EE       15
`define SSRF_MSR_PR       14
`define SSRF_MSR_MASK     32'h0007_ff73

// status register bits
`define SSRF_ST_PRIV      0
`define SSRF_ST_ILL       1
`define SSRF_ST_TIMER     2

`define SSRF_MSR_RST      32'h0000_0000
`define SSRF_DIV_RST      16'h0003
`define SSRF_VERSION      32'h0001_0001
`define SSRF_PIR_RST      32'h0000_0000

`define SSRF_OP_NONE      2'b00
`define SSRF_OP_MTMSR     2'b01
`define SSRF_OP_SC        2'b10
`define SSRF_OP_RFI       2'b11

`endif

// ===== src/ssrf_top.v
// supervisor special register file with time base and countdown timer
// assumes an apb master and core exception logic on pclk
`timescale 1ns/1ps
`include "ssrf_defs.vh"

module ssrf_top #(
    parameter DIV_W = 16,
    parameter [31:0] VERSION_VAL = `SSRF_VERSION,
    parameter [31:0] PIR_VAL = `SSRF_PIR_RST
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire [1:0] msr_op,
    input wire [31:0] msr_op_data,
    input wire exc_take,
    input wire [31:0] exc_pc,
    input wire [31:0] exc_status,
    input wire [31:0] exc_msr,
    input wire fault_take,
    input wire [31:0] fault_ea,
    input wire [31:0] fault_cause,
    input wire fp_exc_take,
    input wire [31:0] fp_exc_cause,
    input wire ext_irq_req,
    output reg [31:0] machine_state_reg,
    output reg [31:0] page_table_base_reg,
    output reg [31:0] save_restore_first,
    output reg [31:0] save_restore_second,
    output reg [31:0] external_access_reg,
    output reg [31:0] data_breakpoint_reg,
    output reg priv_exc,
    output reg illegal_exc,
    output reg timer_irq,
    output reg ext_irq
);

    reg [31:0] fault_address_reg;
    reg [31:0] storage_fault_cause_reg;
    reg [31:0] float_exc_cause_reg;
    reg [63:0] time_base;
    reg [31:0] countdown_timer;
    reg [DIV_W-1:0] div_r;
    reg [DIV_W-1:0] div_cnt_r;
    reg tick_r;
    reg timer_pend_r;
    reg [2:0] stat_r;
    reg [31:0] os_scratch_regs [0:3];
    reg [31:0] block_translation_reg [0:15];
    reg [31:0] segment_regs [0:15];
    reg [31:0] rd_nxt;
    reg acc_err_nxt;
    reg ill_nxt;
    reg priv_nxt;

    wire [9:0] idx = paddr[11:2];
    wire user_mode = machine_state_reg[`SSRF_MSR_PR];
    wire access = psel && penable && !pready;
    wire wr_en = access && pwrite && !acc_err_nxt;
    wire [9:0] sprg_base = {3'b000, `SSRF_IDX_SPRG};
    wire [9:0] bat_base = {3'b000, `SSRF_IDX_BAT};
    wire [9:0] seg_base = {3'b000, `SSRF_IDX_SEG};
    wire is_sprg = idx[9:2] == sprg_base[9:2];
    wire is_bat = idx[9:4] == bat_base[9:4];
    wire is_seg = idx[9:4] == seg_base[9:4];
    wire [31:0] wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
    wire [31:0] dec_nxt = countdown_timer - 32'h0000_0001;
    wire [63:0] tb_inc = time_base + 64'h0000_0000_0000_0001;

    // read mux and access check
    always @* begin
        rd_nxt = 32'h0000_0000;
        ill_nxt = 1'b0;
        if (is_sprg) begin
            rd_nxt = os_scratch_regs[idx[1:0]];
        end else if (is_bat) begin
            rd_nxt = block_translation_reg[idx[3:0]];
        end else if (is_seg) begin
            rd_nxt = segment_regs[idx[3:0]];
        end else begin
            case (idx)
                {3'b000, `SSRF_IDX_MSR}: rd_nxt = machine_state_reg;
                {3'b000, `SSRF_IDX_VER}: rd_nxt = VERSION_VAL;
                {3'b000, `SSRF_IDX_SDR}: rd_nxt = page_table_base_reg;
                {3'b000, `SSRF_IDX_DAR}: rd_nxt = fault_address_reg;
                {3'b000, `SSRF_IDX_STORAGE_FAULT_CAUSE_REG}: rd_nxt = storage_fault_cause_reg;
                {3'b000, `SSRF_IDX_SAVE_RESTORE_FIRST}: rd_nxt = save_restore_first;
                {3'b000, `SSRF_IDX_SAVE_RESTORE_SECOND}: rd_nxt = save_restore_second;
                {3'b000, `SSRF_IDX_FPEC}: rd_nxt = float_exc_cause_reg;
                {3'b000, `SSRF_IDX_TBL}: rd_nxt = time_base[31:0];
                {3'b000, `SSRF_IDX_TBU}: rd_nxt = time_base[63:32];
                {3'b000, `SSRF_IDX_DEC}: rd_nxt = countdown_timer;
                {3'b000, `SSRF_IDX_EAR}: rd_nxt = external_access_reg;
                {3'b000, `SSRF_IDX_DATA_BREAKPOINT_REG}: rd_nxt = data_breakpoint_reg;
                {3'b000, `SSRF_IDX_PIR}: rd_nxt = PIR_VAL;
                {3'b000, `SSRF_IDX_STAT}: rd_nxt = {29'h0000_0000, stat_r};
                {3'b000, `SSRF_IDX_DIV}: rd_nxt = {{(32-DIV_W){1'b0}}, div_r};
                default: ill_nxt = 1'b1;
            endcase
        end
        priv_nxt = !ill_nxt && user_mode &&
            !(!pwrite && (idx == {3'b000, `SSRF_IDX_TBL} || idx == {3'b000, `SSRF_IDX_TBU}));
        acc_err_nxt = ill_nxt || priv_nxt;
    end

    // apb answer, one wait state
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            priv_exc <= 1'b0;
            illegal_exc <= 1'b0;
        end else begin
            pready <= access;
            pslverr <= access && acc_err_nxt;
            prdata <= (access && !pwrite && !acc_err_nxt) ? rd_nxt : 32'h0000_0000;
            priv_exc <= access && priv_nxt;
            illegal_exc <= access && ill_nxt;
        end
    end

    // clock divider tick
    // divided rate
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt_r <= {DIV_W{1'b0}};
            tick_r <= 1'b0;
        end else if (div_cnt_r >= div_r) begin
            div_cnt_r <= {DIV_W{1'b0}};
            tick_r <= 1'b1;
        end else begin
            div_cnt_r <= div_cnt_r + {{(DIV_W-1){1'b0}}, 1'b1};
            tick_r <= 1'b0;
        end
    end

    // general registers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            machine_state_reg <= `SSRF_MSR_RST;
            page_table_base_reg <= 32'h0000_0000;
            save_restore_first <= 32'h0000_0000;
            save_restore_second <= 32'h0000_0000;
            fault_address_reg <= 32'h0000_0000;
            storage_fault_cause_reg <= 32'h0000_0000;
            float_exc_cause_reg <= 32'h0000_0000;
            external_access_reg <= 32'h0000_0000;
            data_breakpoint_reg <= 32'h0000_0000;
            div_r <= `SSRF_DIV_RST;
            time_base <= 64'h0000_0000_0000_0000;
            countdown_timer <= 32'h0000_0000;
        end else begin
            case (msr_op)
                `SSRF_OP_MTMSR, `SSRF_OP_SC: machine_state_reg <= msr_op_data & `SSRF_MSR_MASK;
                `SSRF_OP_RFI: machine_state_reg <= save_restore_second & `SSRF_MSR_MASK;
                default: begin
                    if (exc_take) begin
                        machine_state_reg <= exc_msr & `SSRF_MSR_MASK;
                    end
                end
            endcase
            if (exc_take) begin
                save_restore_first <= exc_pc;
            end else if (wr_en && idx == {3'b000, `SSRF_IDX_SAVE_RESTORE_FIRST}) begin
                save_restore_first <= (save_restore_first & ~wmask) | (pwdata & wmask);
            end
            if (exc_take) begin
                save_restore_second <= exc_status;
            end else if (wr_en && idx == {3'b000, `SSRF_IDX_SAVE_RESTORE_SECOND}) begin
                save_restore_second <= (save_restore_second & ~wmask) | (pwdata & wmask);
            end
            if (fault_take) begin
                fault_address_reg <= fault_ea;
            end else if (wr_en && idx == {3'b000, `SSRF_IDX_DAR}) begin
                fault_address_reg <= (fault_address_reg & ~wmask) | (pwdata & wmask);
            end
            if (fault_take) begin
                storage_fault_cause_reg <= fault_cause;
            end else if (wr_en && idx == {3'b000, `SSRF_IDX_STORAGE_FAULT_CAUSE_REG}) begin
                storage_fault_cause_reg <= (storage_fault_cause_reg & ~wmask) | (pwdata & wmask);
            end
            if (fp_exc_take) begin
                float_exc_cause_reg <= fp_exc_cause;
            end else if (wr_en && idx == {3'b000, `SSRF_IDX_FPEC}) begin
                float_exc_cause_reg <= (float_exc_cause_reg & ~wmask) | (pwdata & wmask);
            end
            if (wr_en && idx == {3'b000, `SSRF_IDX_SDR}) begin
                page_table_base_reg <= (page_table_base_reg & ~wmask) | (pwdata & wmask);
            end
            if (wr_en && idx == {3'b000, `SSRF_IDX_EAR}) begin
                external_access_reg <= (external_access_reg & ~wmask) | (pwdata & wmask);
            end
            if (wr_en && idx == {3'b000, `SSRF_IDX_DATA_BREAKPOINT_REG}) begin
                data_breakpoint_reg <= (data_breakpoint_reg & ~wmask) | (pwdata & wmask);
            end
            if (wr_en && idx == {3'b000, `SSRF_IDX_DIV}) begin
                div_r <= pwdata[DIV_W-1:0];
            end
            if (wr_en && idx == {3'b000, `SSRF_IDX_TBL}) begin
                time_base[31:0] <= (time_base[31:0] & ~wmask) | (pwdata & wmask);
            end else if (wr_en && idx == {3'b000, `SSRF_IDX_TBU}) begin
                time_base[63:32] <= (time_base[63:32] & ~wmask) | (pwdata & wmask);
            end else if (tick_r) begin
                time_base <= tb_inc;
            end
            if (wr_en && idx == {3'b000, `SSRF_IDX_DEC}) begin
                countdown_timer <= (countdown_timer & ~wmask) | (pwdata & wmask);
            end else if (tick_r) begin
                countdown_timer <= dec_nxt;
            end
        end
    end

    // scratch, translation and segment arrays
    genvar g;
    generate
        for (g = 0; g < 16; g = g + 1) begin : g_arr
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    block_translation_reg[g] <= 32'h0000_0000;
                    segment_regs[g] <= 32'h0000_0000;
                end else begin
                    if (wr_en && is_bat && idx[3:0] == g) begin
                        block_translation_reg[g] <= (block_translation_reg[g] & ~wmask) |
                            (pwdata & wmask);
                    end
                    if (wr_en && is_seg && idx[3:0] == g) begin
                        segment_regs[g] <= (segment_regs[g] & ~wmask) | (pwdata & wmask);
                    end
                end
            end
            if (g < 4) begin : g_sprg
                always @(posedge pclk or negedge presetn) begin
                    if (!presetn) begin
                        os_scratch_regs[g] <= 32'h0000_0000;
                    end else if (wr_en && is_sprg && idx[1:0] == g) begin
                        os_scratch_regs[g] <= (os_scratch_regs[g] & ~wmask) | (pwdata & wmask);
                    end
                end
            end
        end
    endgenerate

    // timer pending, status and gated interrupts
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_pend_r <= 1'b0;
            stat_r <= 3'b000;
            timer_irq <= 1'b0;
            ext_irq <= 1'b0;
        end else begin
            if (tick_r && countdown_timer == 32'h0000_0000 &&
                !(wr_en && idx == {3'b000, `SSRF_IDX_DEC})) begin
                timer_pend_r <= 1'b1;
            end else if (exc_take && timer_irq) begin
                timer_pend_r <= 1'b0;
            end
            if (access && priv_nxt) begin
                stat_r[`SSRF_ST_PRIV] <= 1'b1;
            end else if (wr_en && idx == {3'b000, `SSRF_IDX_STAT} && pwdata[`SSRF_ST_PRIV]) begin
                stat_r[`SSRF_ST_PRIV] <= 1'b0;
            end
            if (access && ill_nxt) begin
                stat_r[`SSRF_ST_ILL] <= 1'b1;
            end else if (wr_en && idx == {3'b000, `SSRF_IDX_STAT} && pwdata[`SSRF_ST_ILL]) begin
                stat_r[`SSRF_ST_ILL] <= 1'b0;
            end
            stat_r[`SSRF_ST_TIMER] <= timer_pend_r;
            timer_irq <= timer_pend_r && machine_state_reg[`SSRF_MSR_EE];
            ext_irq <= ext_irq_req && machine_state_reg[`SSRF_MSR_EE];
        end
    end

endmodule // ssrf_top

// ===== sim/ssrf_top_sva.sv
// port assertions for the special register file
// assumes one pclk domain with async active-low presetn
`timescale 1ns/1ps
module ssrf_top_sva (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire [1:0] msr_op,
    input wire [31:0] msr_op_data,
    input wire exc_take,
    input wire [31:0] exc_pc,
    input wire [31:0] exc_status,
    input wire [31:0] machine_state_reg,
    input wire [31:0] save_restore_first,
    input wire [31:0] save_restore_second,
    input wire priv_exc,
    input wire illegal_exc,
    input wire timer_irq,
    input wire ext_irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_PRIV_RESP: assert property (priv_exc |-> pready && pslverr && prdata == 32'h0)
        else $error("privilege refusal without error response");
    AST_ILL_RESP: assert property (illegal_exc |-> pready && pslverr)
        else $error("illegal number without error response");
    AST_ANSWER: assert property (psel && penable && !pready |=> pready)
        else $error("access phase not answered after one wait state");
    AST_PULSE: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    AST_MS_MOVE: assert property (msr_op == 2'b01
        |=> machine_state_reg == ($past(msr_op_data) & 32'h0007_ff73))
        else $error("machine state move not masked copy");
    AST_MS_HOLD: assert property (msr_op == 2'b00 && !exc_take |=> $stable(machine_state_reg))
        else $error("machine state changed without operation");
    AST_SAVE: assert property (exc_take |=> save_restore_first == $past(exc_pc)
        && save_restore_second == $past(exc_status))
        else $error("save registers not loaded on exception");
    AST_GATE: assert property (!machine_state_reg[15] && $past(!machine_state_reg[15])
        |-> !timer_irq && !ext_irq)
        else $error("interrupt seen while enable clear");
    cover property (priv_exc);
    cover property (illegal_exc);
    cover property ($rose(timer_irq));
endmodule // ssrf_top_sva

bind ssrf_top ssrf_top_sva u_ssrf_top_sva (.pclk, .presetn, .psel, .penable, .prdata, .pready,
    .pslverr, .msr_op, .msr_op_data, .exc_take, .exc_pc, .exc_status, .machine_state_reg,
    .save_restore_first, .save_restore_second, .priv_exc, .illegal_exc, .timer_irq, .ext_irq);

// ===== sim/ssrf_core_model.sv
// model of the core execute and exception side
// assumes the register file shares pclk; tasks called by the bench
`timescale 1ns/1ps
module ssrf_core_model (
    input wire pclk,
    output reg [1:0] msr_op,
    output reg [31:0] msr_op_data,
    output reg exc_take,
    output reg [31:0] exc_pc,
    output reg [31:0] exc_status,
    output reg [31:0] exc_msr,
    output reg fault_take,
    output reg [31:0] fault_ea,
    output reg [31:0] fault_cause,
    output reg fp_exc_take,
    output reg [31:0] fp_exc_cause,
    output reg ext_irq_req
);
    initial begin
        {msr_op, msr_op_data, exc_take, exc_pc, exc_status, exc_msr} = 0;
        {fault_take, fault_ea, fault_cause, fp_exc_take, fp_exc_cause, ext_irq_req} = 0;
    end
    task op(input [1:0] o, input [31:0] d);
        @(posedge pclk);
        msr_op <= o;
        msr_op_data <= d;
        @(posedge pclk);
        msr_op <= 2'b00;
        msr_op_data <= ~d;
    endtask
    task exc(input [31:0] pc, input [31:0] st, input [31:0] m);
        @(posedge pclk);
        {exc_take, exc_pc, exc_status, exc_msr} <= {1'b1, pc, st, m};
        @(posedge pclk);
        {exc_take, exc_pc, exc_status, exc_msr} <= {1'b0, ~pc, ~st, ~m};
    endtask
    task fault(input [31:0] ea, input [31:0] c);
        @(posedge pclk);
        {fault_take, fault_ea, fault_cause} <= {1'b1, ea, c};
        @(posedge pclk);
        {fault_take, fault_ea, fault_cause} <= {1'b0, ~ea, ~c};
    endtask
    task fpx(input [31:0] c);
        @(posedge pclk);
        {fp_exc_take, fp_exc_cause} <= {1'b1, c};
        @(posedge pclk);
        {fp_exc_take, fp_exc_cause} <= {1'b0, ~c};
    endtask
    task ext(input v);
        @(posedge pclk);
        ext_irq_req <= v;
    endtask
endmodule // ssrf_core_model

// ===== sim/supervisor_special_reg_file_bench.sv
// self-checking bench for the special register file
// assumes the core model and the checker are compiled before it
`timescale 1ns/1ps
`include "ssrf_defs.vh"
module supervisor_special_reg_file_bench;
    localparam [31:0] VER_V = 32'h5a5a_0102; // arbitrary
    localparam [31:0] PID_V = 32'h0000_0007; // arbitrary
    localparam IX_MS = 0, IX_PTB = 2, IX_FA = 3, IX_FC = 4, IX_FPC = 7, IX_TLO = 8, IX_THI = 9;
    localparam IX_CNT = 10, IX_EXT = 11, IX_BRK = 12, IX_PID = 13, IX_OS = 16;
    reg pclk, presetn, psel, penable, pwrite;
    reg [11:0] paddr;
    reg [31:0] pwdata, rd, v;
    reg [3:0] pstrb;
    reg re, rp, ri;
    wire [31:0] prdata, msr_op_data, exc_pc, exc_status, exc_msr, fault_ea, fault_cause;
    wire [31:0] fp_exc_cause, machine_state_reg, page_table_base_reg, save_restore_first;
    wire [31:0] save_restore_second, external_access_reg, data_breakpoint_reg;
    wire [1:0] msr_op;
    wire pready, pslverr, exc_take, fault_take, fp_exc_take, ext_irq_req;
    wire priv_exc, illegal_exc, timer_irq, ext_irq;
    integer bad_count, n_tests, i, k;

    ssrf_top #(.VERSION_VAL(VER_V), .PIR_VAL(PID_V)) u_ssrf_top (.pclk, .presetn, .psel,
        .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .msr_op,
        .msr_op_data, .exc_take, .exc_pc, .exc_status, .exc_msr, .fault_take, .fault_ea,
        .fault_cause, .fp_exc_take, .fp_exc_cause, .ext_irq_req, .machine_state_reg,
        .page_table_base_reg, .save_restore_first, .save_restore_second,
        .external_access_reg, .data_breakpoint_reg, .priv_exc, .illegal_exc, .timer_irq,
        .ext_irq);
    ssrf_core_model u_ssrf_core_model (.pclk, .msr_op, .msr_op_data, .exc_take, .exc_pc,
        .exc_status, .exc_msr, .fault_take, .fault_ea, .fault_cause, .fp_exc_take,
        .fp_exc_cause, .ext_irq_req);

    task chk(input [63:0] seen, input [63:0] exp);
        n_tests = n_tests + 1;
        if (seen !== exp) begin
            bad_count = bad_count + 1;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task final_report;
        $display("comparisons=%0d mismatches=%0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task apb(input w, input [9:0] ix, input [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, ix, 2'b00, d};
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        @(posedge pclk);
        while (pready !== 1'b1 && k < 20) begin
            @(posedge pclk);
            k = k + 1;
        end
        if (pready !== 1'b1) begin
            bad_count = bad_count + 1;
            final_report;
        end
        {rd, re, rp, ri} = {prdata, pslverr, priv_exc, illegal_exc};
        {psel, penable, pwdata} <= {2'b00, ~d};
    endtask
    task rdc(input [9:0] ix, input [31:0] exp);
        apb(1'b0, ix, 32'h0000_0000);
        chk(rd, exp);
    endtask
    function [9:0] sx(input integer n);
        sx = (n < 4) ? n[9:0] + 10'd16 : n[9:0] + 10'd28;
    endfunction
    task t_regs;
        rdc(`SSRF_IDX_VER, VER_V);
        apb(1'b1, `SSRF_IDX_VER, ~VER_V);
        rdc(`SSRF_IDX_VER, VER_V);
        apb(1'b1, IX_PID, 32'h0000_0055);
        rdc(IX_PID, PID_V);
        for (i = 0; i < 36; i = i + 1) apb(1'b1, sx(i), 32'h5a00_0000 + i * 32'h0001_0101);
        for (i = 0; i < 36; i = i + 1) rdc(sx(i), 32'h5a00_0000 + i * 32'h0001_0101);
        apb(1'b1, IX_PTB, 32'h0012_3400);
        apb(1'b1, IX_EXT, 32'h8000_0003);
        apb(1'b1, IX_BRK, 32'hdead_bee7);
        chk(page_table_base_reg, 32'h0012_3400);
        chk(external_access_reg, 32'h8000_0003);
        chk(data_breakpoint_reg, 32'hdead_bee7);
        apb(1'b0, 10'h01f, 32'h0000_0000);
        chk({re, ri, rp, rd}, {3'b110, 32'h0});
        apb(1'b1, 10'h3ff, 32'hffff_ffff);
        chk({re, ri, rp, 32'h0}, {3'b110, 32'h0});
    endtask
    task t_core;
        u_ssrf_core_model.op(2'b01, 32'hffff_bfff);
        apb(1'b1, IX_MS, 32'h0000_0000);
        rdc(IX_MS, 32'h0007_bf73);
        u_ssrf_core_model.exc(32'h0000_1230, 32'h0000_0032, 32'h0000_0000);
        @(negedge pclk);
        chk(save_restore_first, 32'h0000_1230);
        chk(save_restore_second, 32'h0000_0032);
        u_ssrf_core_model.op(2'b11, 32'h0000_0000);
        @(negedge pclk);
        chk(machine_state_reg, 32'h0000_0032);
        u_ssrf_core_model.op(2'b10, 32'h0000_0001);
        @(negedge pclk);
        chk(machine_state_reg, 32'h0000_0001);
        u_ssrf_core_model.fault(32'h0000_abc4, 32'h0200_0000);
        rdc(IX_FA, 32'h0000_abc4);
        rdc(IX_FC, 32'h0200_0000);
        u_ssrf_core_model.fpx(32'h0000_0011);
        rdc(IX_FPC, 32'h0000_0011);
        u_ssrf_core_model.op(2'b01, 32'h0000_4000);
        apb(1'b1, IX_OS, 32'h0bad_0bad);
        chk({re, ri, rp, rd}, {3'b101, 32'h0});
        apb(1'b0, IX_TLO, 32'h0000_0000);
        chk({re, rp}, 2'b00);
        apb(1'b0, IX_THI, 32'h0000_0000);
        chk({re, rp}, 2'b00);
        u_ssrf_core_model.op(2'b01, 32'h0000_0000);
        rdc(IX_OS, 32'h5a00_0000);
        apb(1'b1, `SSRF_IDX_STAT, 32'h0000_0003);
    endtask
    task t_time;
        apb(1'b1, `SSRF_IDX_DIV, 32'h0000_0000);
        apb(1'b1, IX_THI, 32'hffff_ffff);
        apb(1'b1, IX_TLO, 32'hffff_fff0);
        repeat (30) @(posedge pclk);
        rdc(IX_THI, 32'h0000_0000);
        apb(1'b0, IX_TLO, 32'h0000_0000);
        v = rd;
        repeat (100) @(posedge pclk);
        apb(1'b0, IX_TLO, 32'h0000_0000);
        chk(rd - v, 32'd104);
        apb(1'b1, IX_CNT, 32'h0000_0003);
        repeat (20) @(posedge pclk);
        chk({31'h0, timer_irq}, 32'h0);
        rdc(`SSRF_IDX_STAT, 32'h0000_0004);
        u_ssrf_core_model.op(2'b01, 32'h0000_8000);
        k = 0;
        while (timer_irq !== 1'b1 && k < 8) begin
            @(posedge pclk);
            k = k + 1;
        end
        chk({31'h0, timer_irq}, 32'h1);
        if (timer_irq !== 1'b1) begin
            final_report;
        end
        apb(1'b0, IX_CNT, 32'h0000_0000);
        chk({31'h0, rd[31]}, 32'h1);
        u_ssrf_core_model.exc(32'h0000_0000, 32'h0000_0000, 32'h0000_8000);
        // irq output follows the cleared pending flag one edge later
        @(posedge pclk);
        @(negedge pclk);
        chk({31'h0, timer_irq}, 32'h0);
        u_ssrf_core_model.ext(1'b1);
        repeat (3) @(posedge pclk);
        chk({31'h0, ext_irq}, 32'h1);
        u_ssrf_core_model.op(2'b01, 32'h0000_0000);
        @(posedge pclk);
        @(negedge pclk);
        chk({31'h0, ext_irq}, 32'h0);
        u_ssrf_core_model.ext(1'b0);
    endtask

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, bad_count, n_tests} = 0;
        pstrb = 4'hf;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rdc(IX_MS, 32'h0000_0000);
        t_regs;
        t_core;
        t_time;
        final_report;
    end
endmodule // supervisor_special_reg_file_bench
